// ===== bench/ds3_oh_insert_test.sv
module ds3_oh_insert_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, reset_i = 1'b1, own_bit_i = 1'b0, oh_ready_i = 1'b0, oh_clk_d = 1'b0;
  logic oh_clk, frame, ins_en, ins_dat, oh_valid, oh_bit, oh_ins;
  ds3_oh_pkg::oh_count_t oh_pos, bit_pos;
  logic [5:0]  far_cnt;
  logic [55:0] plan_en, plan_dat, own_tab;
  int          bad_count = 0, compares = 0, cycles = 0, exp_pos = 0, low_run = 0, max_low = 0;
  int unsigned seed = 13, r;
  always #10 clk_i = ~clk_i;
  ds3_oh_insert i_dut (.clk_i(clk_i), .reset_i(reset_i), .overhead_clock_out_o(oh_clk),
    .overhead_frame_marker_o(frame), .overhead_insert_enable_i(ins_en), .overhead_data_in_i(ins_dat),
    .own_bit_i(own_bit_i), .oh_pos_o(oh_pos), .oh_valid_o(oh_valid), .oh_ready_i(oh_ready_i),
    .oh_bit_o(oh_bit), .oh_bit_pos_o(bit_pos), .oh_inserted_o(oh_ins));
  oh_far_end i_far (.clk_i(clk_i), .oh_clk_i(oh_clk), .frame_i(frame), .plan_en_i(plan_en),
    .plan_dat_i(plan_dat), .ins_en_o(ins_en), .ins_dat_o(ins_dat), .cnt_o(far_cnt));
  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Insertable slots of the frame start
  function automatic logic can_ins(int p);
    return (p % 2 == 0) && (p <= 28) && (p != 16) && (p != 24);
  endfunction
  // Expected slot value: far end if taken, else F1 one, F0 zero, own bit on even slots
  function automatic logic exp_bit(int p);
    if (plan_en[p] && can_ins(p)) return plan_dat[p];
    return (p % 2 == 0) ? own_tab[p] : (p % 8 == 1 || p % 8 == 7);
  endfunction
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    compares++;
    if (exp !== got) begin
      bad_count++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Own bit follows the device position
  always @(negedge clk_i) own_bit_i <= reset_i ? 1'b0 : own_tab[oh_pos];
  // Drained words against the model; pins checked at each rise
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      $display("timeout");
      end_sim();
    end
    low_run = oh_clk ? 0 : low_run + 1;
    if (low_run > max_low) max_low = low_run;
    if (!reset_i && oh_clk && !oh_clk_d) begin
      check("edge count", far_cnt, oh_pos);
      check("marker", oh_pos == 0, frame);
    end
    oh_clk_d <= oh_clk;
    if (!reset_i && oh_valid && oh_ready_i) begin
      check("position", exp_pos, bit_pos);
      check("inserted", plan_en[exp_pos] && can_ins(exp_pos), oh_ins);
      check("bit", exp_bit(exp_pos), oh_bit);
      exp_pos = (exp_pos + 1) % 56;
    end
  end
  // Main sequence
  initial begin
    for (int i = 0; i < 56; i++) begin
      r = xs();
      plan_en[i] = (i <= 28) | r[0];
      plan_dat[i] = r[1];
      own_tab[i] = r[2];
    end
    repeat (3) @(posedge clk_i);
    @(negedge clk_i) reset_i = 1'b0;
    repeat (1344) begin
      @(negedge clk_i);
      r = xs();
      oh_ready_i = r[0] | r[1];
    end
    $display("test random drain done");
    oh_ready_i = 1'b0;
    max_low = 0;
    repeat (320) @(negedge clk_i);
    check("clock held while full", 1'b1, max_low > 8);
    check("valid while full", 1'b1, oh_valid);
    oh_ready_i = 1'b1;
    repeat (400) @(negedge clk_i);
    $display("test full stall done");
    reset_i = 1'b1;
    repeat (3) @(negedge clk_i);
    check("marker in reset", 1'b1, frame);
    check("valid in reset", 1'b0, oh_valid);
    exp_pos = 0;
    // Random enables now, so open slots left to the device are seen too
    for (int i = 0; i < 56; i++) begin
      r = xs();
      plan_en[i] = r[0];
    end
    reset_i = 1'b0;
    repeat (500) @(negedge clk_i);
    $display("test second reset done");
    end_sim();
  end
endmodule

// ===== bench/oh_far_end.sv
module oh_far_end (
  // Clock
  input  wire logic        clk_i,
  // Device pins seen
  input  wire logic        oh_clk_i,
  input  wire logic        frame_i,
  // Insertion plan per position
  input  wire logic [55:0] plan_en_i,
  input  wire logic [55:0] plan_dat_i,
  // Pins driven
  output logic             ins_en_o,
  output logic             ins_dat_o,
  output logic [5:0]       cnt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       last_clk;
  logic [5:0] nxt;
  initial begin
    ins_en_o = 1'b0;
    ins_dat_o = 1'b0;
    cnt_o = 6'h00;
    last_clk = 1'b0;
  end
  // Edge found by oversampling; pins held a whole period
  always @(negedge clk_i) begin
    if (oh_clk_i && !last_clk) begin
      nxt = frame_i ? 6'h00 : cnt_o + 6'h01;
      cnt_o <= nxt;
      // Enable and data for target bit
      ins_en_o <= plan_en_i[nxt];
      // Idle data toggles so a stale value never matches
      ins_dat_o <= plan_en_i[nxt] ? plan_dat_i[nxt] : ~ins_dat_o;
    end
    last_clk <= oh_clk_i;
  end
endmodule

// ===== logic/ds3_oh_insert.sv
// Contract
// - The device shows the frame marker high at the rising edge that starts a new frame.
// - At count zero the device handles X bit one and accepts an inserted value for it.
// - At odd counts 1 to 27 the device handles framing bits and refuses insertion.
// - At counts 16 and 24 the device handles parity bits and refuses insertion.
// - Counts 2, 4 and 6 (C11, C12, C13) accept inserted values.
// - Count 8 (X bit two) and counts 10, 12, 14 (C21 to C23) accept inserted values.
// - Counts 18, 20 and 22 (C31 to C33) accept inserted values.
// - Counts 26 and 28 (C41, C42) accept inserted values.
// - An accepted bit is placed in its own position of the outbound stream.
// - While insert enable is high the data pin is latched at the falling overhead clock edge.
// - An insertion at a non-insertable bit is ignored and the device's own value kept.
`include "ds3_oh_regs.svh"

module ds3_oh_fifo #(
  parameter int WIDTH = `OH_FIFO_WIDTH,
  parameter int DEPTH = `OH_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wr;
    logic [AW:0]                 rd;
  } fifo_state_t;

  fifo_state_t s_reg;
  fifo_state_t s_next;
  logic        full;
  logic        empty;

  // Extra pointer bit tells full from empty
  assign full        = (s_reg.wr[AW] != s_reg.rd[AW]) && (s_reg.wr[AW-1:0] == s_reg.rd[AW-1:0]);
  assign empty       = (s_reg.wr == s_reg.rd);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = s_reg.mem[s_reg.rd[AW-1:0]];

  // Pointer and storage update
  always_comb begin
    s_next = s_reg;
    if (in_valid_i && !full) begin
      s_next.mem[s_reg.wr[AW-1:0]] = in_data_i;
      s_next.wr = s_reg.wr + 1'b1;
    end
    if (out_ready_i && !empty) begin
      s_next.rd = s_reg.rd + 1'b1;
    end
  end

  // Reset clears the storage as well as the pointers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_reg.mem <= '0;
      s_reg.wr  <= '0;
      s_reg.rd  <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule

module ds3_oh_insert #(
  parameter int FRAME_BITS = `OH_FRAME_BITS,
  parameter int FIFO_DEPTH = `OH_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   reset_i,
  // Overhead insertion pins
  output logic                        overhead_clock_out_o,
  output logic                        overhead_frame_marker_o,
  input  wire logic                   overhead_insert_enable_i,
  input  wire logic                   overhead_data_in_i,
  // Device's own value for every even bit not taken from the far end
  input  wire logic                   own_bit_i,
  output ds3_oh_pkg::oh_count_t       oh_pos_o,
  // Outbound overhead stream
  output logic                        oh_valid_o,
  input  wire logic                   oh_ready_i,
  output logic                        oh_bit_o,
  output ds3_oh_pkg::oh_count_t       oh_bit_pos_o,
  output logic                        oh_inserted_o
);
  localparam logic [2:0]            HALF   = 3'(`OH_HALF_CYCLES);
  localparam logic [2:0]            SAMPLE = 3'(`OH_SAMPLE_PHASE);
  localparam ds3_oh_pkg::oh_count_t LAST   = 6'(FRAME_BITS - 1);

  ds3_oh_pkg::port_state_t s_reg;
  ds3_oh_pkg::port_state_t s_next;
  logic                    push_valid;
  logic                    push_ready;
  logic                    accepted;
  logic                    push_bit;
  logic [7:0]              fifo_out;

  // Positions the far end may overwrite
  // Accepted even slots
  function automatic logic insertable(input ds3_oh_pkg::oh_count_t c);
    insertable = (c <= `OH_LAST_INSERT) && !c[0] && (c != `OH_PARITY_A) && (c != `OH_PARITY_B);
  endfunction

  // Device value: F1 is one, F0 is zero, others from the generator
  // Framing pattern generated
  function automatic logic own_value(input ds3_oh_pkg::oh_count_t c, input logic gen);
    own_value = c[0] ? (c[2:1] == 2'b00 || c[2:1] == 2'b11) : gen;
  endfunction

  // Sampling decision taken once per overhead period
  always_comb begin
    push_valid = (s_reg.phase == SAMPLE);
    accepted   = s_reg.ins_s2 && insertable(s_reg.count);
    push_bit   = accepted ? s_reg.dat_s2 : own_value(s_reg.count, own_bit_i);
  end

  // Divider, edge counter and pin synchronisers
  always_comb begin
    s_next        = s_reg;
    s_next.ins_s1 = overhead_insert_enable_i;
    s_next.ins_s2 = s_reg.ins_s1;
    s_next.dat_s1 = overhead_data_in_i;
    s_next.dat_s2 = s_reg.dat_s1;
    // A full FIFO stops the overhead clock low
    if (!(push_valid && !push_ready)) begin
      s_next.phase = s_reg.phase + 3'h1;
    end
    s_next.clk = (s_next.phase < HALF);
    if (s_next.phase == 3'h0 && s_reg.phase != 3'h0) begin
      s_next.count = (s_reg.count == LAST) ? 6'h00 : s_reg.count + 6'h01;
    end
    // Marker set at falling edge ahead of count zero
    if (s_next.phase == HALF && s_reg.phase != HALF) begin
      s_next.frame = (s_reg.count == LAST);
    end
  end

  // Reset parks the port just before the first frame
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_reg.phase  <= SAMPLE + 3'h1;  // No sample slot before count zero
      s_reg.count  <= LAST;
      s_reg.clk    <= 1'b0;
      s_reg.frame  <= 1'b1;
      s_reg.ins_s1 <= 1'b0;
      s_reg.ins_s2 <= 1'b0;
      s_reg.dat_s1 <= 1'b0;
      s_reg.dat_s2 <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign overhead_clock_out_o    = s_reg.clk;
  assign overhead_frame_marker_o = s_reg.frame;
  assign oh_pos_o                = s_reg.count;

  // Bit and its position into the outbound path
  ds3_oh_fifo #(
    .WIDTH(`OH_FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i      (clk_i),
    .reset_i    (reset_i),
    .in_valid_i (push_valid),
    .in_ready_o (push_ready),
    .in_data_i  ({accepted, s_reg.count, push_bit}),
    .out_valid_o(oh_valid_o),
    .out_ready_i(oh_ready_i),
    .out_data_o (fifo_out)
  );

  assign oh_inserted_o = fifo_out[7];
  assign oh_bit_pos_o  = fifo_out[6:1];
  assign oh_bit_o      = fifo_out[0];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  frame_marker_edge_a: assert property ($rose(overhead_clock_out_o) |->
    overhead_frame_marker_o == (oh_pos_o == 6'h00))
    else $error("frame marker wrong at rising edge");

  xbit_one_accept_a: assert property (push_valid && s_reg.count == 6'h00 && s_reg.ins_s2 |->
    accepted && push_bit == s_reg.dat_s2)
    else $error("X bit one not accepted");

  framing_refused_a: assert property (push_valid && s_reg.count[0] |->
    !accepted && push_bit == (s_reg.count[2:1] == 2'b00 || s_reg.count[2:1] == 2'b11))
    else $error("framing bit overwritten");

  parity_refused_a: assert property (push_valid && (s_reg.count == 6'h10 || s_reg.count == 6'h18) |->
    !accepted)
    else $error("parity bit overwritten");

  first_cbits_accept_a: assert property (push_valid && s_reg.ins_s2 &&
    (s_reg.count == 6'h02 || s_reg.count == 6'h04 || s_reg.count == 6'h06) |-> accepted)
    else $error("C1 bit not accepted");

  link_bits_accept_a: assert property (push_valid && s_reg.ins_s2 &&
    (s_reg.count == 6'h08 || s_reg.count == 6'h0A || s_reg.count == 6'h0C || s_reg.count == 6'h0E) |-> accepted)
    else $error("X2 or C2 bit not accepted");

  cparity_accept_a: assert property (push_valid && s_reg.ins_s2 &&
    (s_reg.count == 6'h12 || s_reg.count == 6'h14 || s_reg.count == 6'h16) |-> accepted)
    else $error("C3 bit not accepted");

  febe_accept_a: assert property (push_valid && s_reg.ins_s2 &&
    (s_reg.count == 6'h1A || s_reg.count == 6'h1C) |-> accepted)
    else $error("C4 bit not accepted");

  stream_value_a: assert property (push_valid && push_ready && accepted && !oh_valid_o |=>
    fifo_out == {1'b1, $past(s_reg.count), $past(s_reg.dat_s2)})
    else $error("inserted bit lost");

  falling_sample_a: assert property (push_valid && !$past(push_valid) |->
    !$past(overhead_clock_out_o, 2) && $past(overhead_clock_out_o, 3))
    else $error("data not taken at falling edge");

  refused_own_a: assert property (push_valid && s_reg.ins_s2 &&
    (s_reg.count[0] || s_reg.count > 6'h1C || s_reg.count == 6'h10 || s_reg.count == 6'h18) |->
    !accepted &&
    push_bit == (s_reg.count[0] ? (s_reg.count[2:1] == 2'b00 || s_reg.count[2:1] == 2'b11) : own_bit_i))
    else $error("ignored insertion changed bit");
endmodule

// ===== logic/ds3_oh_pkg.sv
package ds3_oh_pkg;

  // Position of the overhead bit inside the M-frame
  typedef logic [5:0] oh_count_t;

  // Whole state of the insertion port
  typedef struct packed {
    logic [2:0] phase;
    oh_count_t  count;
    logic       clk;
    logic       frame;
    logic       ins_s1;
    logic       ins_s2;
    logic       dat_s1;
    logic       dat_s2;
  } port_state_t;

endpackage

// ===== logic/ds3_oh_regs.svh
`ifndef DS3_OH_REGS_SVH
`define DS3_OH_REGS_SVH

// System clock and overhead clock periods
`define OH_SYS_CLK_NS     20
`define OH_LINK_CLK_NS    160
`define OH_LINK_CYCLES    (`OH_LINK_CLK_NS / `OH_SYS_CLK_NS)
`define OH_HALF_CYCLES    (`OH_LINK_CYCLES / 2)
// Phase at which the data pin is taken: two cycles after the falling edge
`define OH_SAMPLE_PHASE   (`OH_HALF_CYCLES + 2)

// Overhead positions in one DS3 M-frame
`define OH_FRAME_BITS     56
`define OH_LAST_INSERT    6'h1C
`define OH_PARITY_A       6'h10
`define OH_PARITY_B       6'h18

// Outbound FIFO shape
`define OH_FIFO_DEPTH     32
`define OH_FIFO_WIDTH     8

`endif
